// ===== hw/csfbs_regs.svh
// offsets, field positions and reset values of the status register block
`ifndef CSFBS_REGS_SVH
`define CSFBS_REGS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define CSFBS_OFS_FLAGS_BANK 8'h00
`define CSFBS_OFS_BANK_VIEW 8'h04

// ------------------------------------------------------------------
// field positions in alu_flags_and_bank_select
// ------------------------------------------------------------------
`define CSFBS_BIT_INDIRECT_BANK 7
`define CSFBS_BIT_BANK_HIGH 6
`define CSFBS_BIT_BANK_LOW 5
`define CSFBS_BIT_WDOG_EXPIRY 4
`define CSFBS_BIT_SLEEP_ENTERED 3
`define CSFBS_BIT_ZERO 2
`define CSFBS_BIT_NIBBLE_CARRY 1
`define CSFBS_BIT_CARRY 0

// ------------------------------------------------------------------
// reset value and write masks
// ------------------------------------------------------------------
`define CSFBS_RESET_VALUE 8'h18
`define CSFBS_SW_WRITE_MASK 8'hE7
`define CSFBS_BANK_WRITE_MASK 8'hE0

// ------------------------------------------------------------------
// bus responses
// ------------------------------------------------------------------
`define CSFBS_RESP_OKAY 2'h0
`define CSFBS_RESP_DECERR 2'h3

`endif

// ===== hw/csfbs_pkg.sv
// types shared by the status register block
package csfbs_pkg;

  // ------------------------------------------------------------------
  // core operations presented to the block
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none,
    op_add,
    op_sub,
    op_and,
    op_or,
    op_xor,
    op_inc,
    op_dec,
    op_register_wipe,
    op_working_to_register_move,
    op_nibble_exchange,
    op_bit_reset,
    op_bit_raise
  } csfbs_op_type;

  // ------------------------------------------------------------------
  // block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] bank_onehot;
    logic indirect_upper;
    logic [7:0] result;
    logic result_valid;
    logic awready;
    logic wready;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csfbs_state_type;

endpackage : csfbs_pkg

// ===== hw/csfbs_flag_alu.sv
// result and flag outcome of one core operation
`timescale 1ns/1ns
`default_nettype none

module csfbs_flag_alu (
  // operation
  input wire csfbs_pkg::csfbs_op_type op,
  input wire logic [7:0] operand_w,
  input wire logic [7:0] operand_f,
  input wire logic [2:0] bit_index,
  // outcome
  output logic [7:0] result,
  output logic zero,
  output logic nibble_carry,
  output logic carry,
  output logic zero_upd,
  output logic carry_upd
);

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    result = operand_f;
    nibble_carry = 1'b0;
    carry = 1'b0;
    zero_upd = 1'b0;
    carry_upd = 1'b0;
    case (op)
      csfbs_pkg::op_add: begin
        sum = {1'b0, operand_f} + {1'b0, operand_w};
        nib = {1'b0, operand_f[3:0]} + {1'b0, operand_w[3:0]};
        result = sum[7:0];
        carry = sum[8];
        nibble_carry = nib[4];
        zero_upd = 1'b1;
        carry_upd = 1'b1;
      end
      csfbs_pkg::op_sub: begin
        result = operand_f - operand_w;
        carry = (operand_f >= operand_w); // [RL7]
        nibble_carry = (operand_f[3:0] >= operand_w[3:0]); // [RL7]
        zero_upd = 1'b1;
        carry_upd = 1'b1;
      end
      csfbs_pkg::op_and: begin
        result = operand_f & operand_w;
        zero_upd = 1'b1;
      end
      csfbs_pkg::op_or: begin
        result = operand_f | operand_w;
        zero_upd = 1'b1;
      end
      csfbs_pkg::op_xor: begin
        result = operand_f ^ operand_w;
        zero_upd = 1'b1;
      end
      csfbs_pkg::op_inc: begin
        result = operand_f + 8'h01;
        zero_upd = 1'b1;
      end
      csfbs_pkg::op_dec: begin
        result = operand_f - 8'h01;
        zero_upd = 1'b1;
      end
      csfbs_pkg::op_register_wipe: begin
        result = 8'h00; // [RL4]
        zero_upd = 1'b1; // [RL4]
      end
      csfbs_pkg::op_working_to_register_move: begin
        result = operand_w; // [RL5]
      end
      csfbs_pkg::op_nibble_exchange: begin
        result = {operand_f[3:0], operand_f[7:4]}; // [RL5]
      end
      csfbs_pkg::op_bit_reset: begin
        result = operand_f & ~(8'h01 << bit_index); // [RL5]
      end
      csfbs_pkg::op_bit_raise: begin
        result = operand_f | (8'h01 << bit_index); // [RL5]
      end
      default: begin
        result = operand_f;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule : csfbs_flag_alu

`default_nettype wire

// ===== hw/csfbs_top.sv
// core status register with flags, reset cause and bank select
//
// Function
// RL1 - status register is a legal destination of any core operation.
// RL2 - flag-updating operation into status drops data write to three flags.
// RL3 - software writes to bits 4 and 3 are ignored.
// RL4 - wipe of status zeroes upper three bits, sets zero flag only.
// RL5 - bit reset, bit raise, nibble exchange, move leave flags untouched.
// RL6 - direct bank bits select banks 0-3; indirect bit selects upper half.
// RL7 - subtraction drives carry and nibble carry as inverted borrow.
// RL8 - kick, sleep and watchdog expiry steer the two reset-cause flags.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "csfbs_regs.svh"

module csfbs_top #(
  parameter int AXI_ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core operation
  input wire logic core_op_valid,
  input wire csfbs_pkg::csfbs_op_type core_op,
  input wire logic [7:0] core_operand_w,
  input wire logic [7:0] core_operand_f,
  input wire logic [2:0] core_bit_index,
  input wire logic core_dest_status,
  // hardware events
  input wire logic watchdog_kick_instr,
  input wire logic sleep_entry,
  input wire logic watchdog_timeout,
  // core view
  output logic [7:0] alu_flags_and_bank_select,
  output logic [3:0] direct_bank_onehot,
  output logic indirect_bank_bit,
  output logic [7:0] core_result,
  output logic core_result_valid,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  csfbs_pkg::csfbs_state_type q;
  csfbs_pkg::csfbs_state_type next_q;

  logic [7:0] alu_f;
  logic [7:0] alu_result;
  logic alu_zero;
  logic alu_nibble_carry;
  logic alu_carry;
  logic alu_zero_upd;
  logic alu_carry_upd;
  logic [7:0] stat;
  logic [7:0] rd_addr;
  logic [7:0] wr_addr;
  logic unused_prot;

  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // ------------------------------------------------------------------
  // operand and flag computation
  // ------------------------------------------------------------------
  // status read back like any file register
  assign alu_f = core_dest_status ? q.status : core_operand_f; // [RL1]

  csfbs_flag_alu u_flag_alu (
    .op(core_op),
    .operand_w(core_operand_w),
    .operand_f(alu_f),
    .bit_index(core_bit_index),
    .result(alu_result),
    .zero(alu_zero),
    .nibble_carry(alu_nibble_carry),
    .carry(alu_carry),
    .zero_upd(alu_zero_upd),
    .carry_upd(alu_carry_upd)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_q = q;
    stat = q.status;
    rd_addr = 8'h00;
    wr_addr = 8'h00;
    next_q.result_valid = 1'b0;

    // write address and data capture
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // core operation has priority over a bus write
    if (core_op_valid) begin
      next_q.result = alu_result;
      next_q.result_valid = 1'b1;
      if (core_dest_status) begin
        // reset-cause bits never take data
        if (alu_zero_upd || alu_carry_upd) begin
          // flag-updating op: data reaches the bank bits only
          stat = (stat & ~`CSFBS_BANK_WRITE_MASK)
            | (alu_result & `CSFBS_BANK_WRITE_MASK); // [RL2] [RL4]
        end else begin
          stat = (stat & ~`CSFBS_SW_WRITE_MASK)
            | (alu_result & `CSFBS_SW_WRITE_MASK); // [RL1] [RL3] [RL5]
        end
      end
      // flag outcome overrides any data write to the flags
      if (alu_zero_upd) begin
        stat[`CSFBS_BIT_ZERO] = alu_zero; // [RL2] [RL4]
      end
      if (alu_carry_upd) begin
        stat[`CSFBS_BIT_NIBBLE_CARRY] = alu_nibble_carry; // [RL2] [RL7]
        stat[`CSFBS_BIT_CARRY] = alu_carry; // [RL2] [RL7]
      end
    end else if (q.aw_have && q.w_have && !q.bvalid) begin
      wr_addr = q.aw_addr;
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      if (wr_addr == `CSFBS_OFS_FLAGS_BANK) begin
        next_q.bresp = `CSFBS_RESP_OKAY;
        if (q.w_strb[0]) begin
          stat = (stat & ~`CSFBS_SW_WRITE_MASK)
            | (q.w_data[7:0] & `CSFBS_SW_WRITE_MASK); // [RL3]
        end
      end else if (wr_addr == `CSFBS_OFS_BANK_VIEW) begin
        next_q.bresp = `CSFBS_RESP_OKAY;
      end else begin
        next_q.bresp = `CSFBS_RESP_DECERR;
      end
    end

    // hardware events on the reset-cause flags
    if (watchdog_kick_instr) begin
      stat[`CSFBS_BIT_WDOG_EXPIRY] = 1'b1; // [RL8]
      stat[`CSFBS_BIT_SLEEP_ENTERED] = 1'b1; // [RL8]
    end
    if (sleep_entry) begin
      stat[`CSFBS_BIT_WDOG_EXPIRY] = 1'b1; // [RL8]
      stat[`CSFBS_BIT_SLEEP_ENTERED] = 1'b0; // [RL8]
    end
    if (watchdog_timeout) begin
      stat[`CSFBS_BIT_WDOG_EXPIRY] = 1'b0; // [RL8]
    end
    next_q.status = stat;

    // bank decode
    case ({stat[`CSFBS_BIT_BANK_HIGH], stat[`CSFBS_BIT_BANK_LOW]})
      2'b00: next_q.bank_onehot = 4'h1; // [RL6]
      2'b01: next_q.bank_onehot = 4'h2; // [RL6]
      2'b10: next_q.bank_onehot = 4'h4; // [RL6]
      2'b11: next_q.bank_onehot = 4'h8; // [RL6]
      default: next_q.bank_onehot = 4'h1;
    endcase
    next_q.indirect_upper = stat[`CSFBS_BIT_INDIRECT_BANK]; // [RL6]

    next_q.awready = !next_q.aw_have && !next_q.bvalid;
    next_q.wready = !next_q.w_have && !next_q.bvalid;

    // read channel
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      rd_addr = 8'(s_axi_araddr);
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = `CSFBS_RESP_OKAY;
      if (rd_addr == `CSFBS_OFS_FLAGS_BANK) begin
        next_q.rdata = {24'h00_0000, q.status};
      end else if (rd_addr == `CSFBS_OFS_BANK_VIEW) begin
        next_q.rdata = {27'h000_0000, q.indirect_upper, q.bank_onehot};
      end else begin
        next_q.rdata = 32'h0000_0000;
        next_q.rresp = `CSFBS_RESP_DECERR;
      end
    end else if (!q.rvalid) begin
      next_q.arready = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.status <= `CSFBS_RESET_VALUE; // [RL8]
      q.bank_onehot <= 4'h1;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign alu_flags_and_bank_select = q.status;
  assign direct_bank_onehot = q.bank_onehot;
  assign indirect_bank_bit = q.indirect_upper;
  assign core_result = q.result;
  assign core_result_valid = q.result_valid;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

endmodule : csfbs_top

`default_nettype wire

// ===== verif/csfbs_top_asserts.sv
// assertion checker for the status register block
`timescale 1ns/1ns
`default_nettype none

module csfbs_top_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core operation and events
  input wire logic core_op_valid,
  input wire csfbs_pkg::csfbs_op_type core_op,
  input wire logic core_dest_status,
  input wire logic watchdog_kick_instr,
  input wire logic sleep_entry,
  input wire logic watchdog_timeout,
  // core view
  input wire logic [7:0] alu_flags_and_bank_select,
  input wire logic [3:0] direct_bank_onehot,
  input wire logic indirect_bank_bit,
  input wire logic core_result_valid
);
  // ----------
  // helpers
  // ----------
  wire logic [7:0] st = alu_flags_and_bank_select;
  wire logic quiet = !watchdog_kick_instr && !sleep_entry && !watchdog_timeout;
  wire logic keep_op = core_op_valid && !core_dest_status &&
    core_op inside {csfbs_pkg::op_bit_reset, csfbs_pkg::op_bit_raise,
    csfbs_pkg::op_nibble_exchange, csfbs_pkg::op_working_to_register_move};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_BANK_DECODE: assert property (direct_bank_onehot == 4'h1 << st[6:5])
    else $error("bank one-hot wrong");
  AST_INDIRECT: assert property (indirect_bank_bit == st[7])
    else $error("indirect bank wrong");
  AST_KICK: assert property (watchdog_kick_instr && !sleep_entry &&
    !watchdog_timeout |=> st[4:3] == 2'h3)
    else $error("kick did not set reset-cause flags");
  AST_SLEEP: assert property (sleep_entry && !watchdog_timeout |=>
    st[4:3] == 2'h2)
    else $error("sleep entry flags wrong");
  AST_TIMEOUT: assert property (watchdog_timeout |=> !st[4])
    else $error("timeout did not clear expiry flag");
  AST_RC_HOLD: assert property (quiet |=> st[4:3] == $past(st[4:3]))
    else $error("reset-cause flags changed without event");
  AST_WIPE: assert property (core_op_valid && core_dest_status && quiet &&
    core_op == csfbs_pkg::op_register_wipe |=> st[7:5] == 3'h0 && st[2] &&
    st[1:0] == $past(st[1:0]))
    else $error("wipe of status wrong");
  AST_NO_FLAG: assert property (keep_op && quiet |=> st == $past(st))
    else $error("flag-neutral op changed status");
  AST_RESULT: assert property (core_op_valid |=> core_result_valid)
    else $error("no result after op");
endmodule : csfbs_top_asserts

`default_nettype wire

// ===== verif/csfbs_top_test.sv
// self-checking bench for the status register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end

bind csfbs_top csfbs_top_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
  .core_op_valid(core_op_valid), .core_op(core_op),
  .core_dest_status(core_dest_status),
  .watchdog_kick_instr(watchdog_kick_instr), .sleep_entry(sleep_entry),
  .watchdog_timeout(watchdog_timeout),
  .alu_flags_and_bank_select(alu_flags_and_bank_select),
  .direct_bank_onehot(direct_bank_onehot),
  .indirect_bank_bit(indirect_bank_bit), .core_result_valid(core_result_valid));

module csfbs_top_test;
  logic aclk = 0, rstn = 0, opv = 0, dst = 0, kk = 0, sl = 0, tmo = 0;
  logic awv = 0, wv = 0, bb = 0, arv = 0, rr = 0;
  logic [7:0] ow = 0, of = 0, aa = 0, ra = 0, fl, res, m;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0, oh;
  logic [2:0] bi = 0;
  logic [1:0] br, rs;
  logic ib, rv, awr, wrdy, bv, arr, rvl;
  csfbs_pkg::csfbs_op_type op = csfbs_pkg::op_none;
  csfbs_pkg::csfbs_op_type ops[12] = '{csfbs_pkg::op_add, csfbs_pkg::op_sub,
    csfbs_pkg::op_and, csfbs_pkg::op_register_wipe,
    csfbs_pkg::op_working_to_register_move, csfbs_pkg::op_nibble_exchange,
    csfbs_pkg::op_bit_reset, csfbs_pkg::op_bit_raise, csfbs_pkg::op_or,
    csfbs_pkg::op_xor, csfbs_pkg::op_inc, csfbs_pkg::op_dec};
  int n_errors = 0, num_checks = 0, cyc = 0;
  integer seed = 32'hac69_7601;

  always #10 aclk = ~aclk;

  csfbs_top u_dut (.aclk(aclk), .aresetn(rstn), .core_op_valid(opv),
    .core_op(op), .core_operand_w(ow), .core_operand_f(of),
    .core_bit_index(bi), .core_dest_status(dst), .watchdog_kick_instr(kk),
    .sleep_entry(sl), .watchdog_timeout(tmo), .alu_flags_and_bank_select(fl),
    .direct_bank_onehot(oh), .indirect_bank_bit(ib), .core_result(res),
    .core_result_valid(rv), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(aa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bb), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ra),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvl), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rs));

  // ----------
  // bus and core tasks
  // ----------
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
    logic [1:0] er);
    @(posedge aclk);
    awv <= 1;
    wv <= 1;
    aa <= a;
    wd <= d;
    ws <= s;
    bb <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    bb <= 0;
    `CHK(br, er)
  endtask : wr

  task automatic rd_chk(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge aclk);
    arv <= 1;
    ra <= a;
    rr <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (!rvl);
    rr <= 0;
    `CHK(rd, ed)
    `CHK(rs, er)
  endtask : rd_chk

  task automatic do_op(csfbs_pkg::csfbs_op_type o, logic d);
    logic [8:0] r;
    logic [7:0] w, f;
    logic [2:0] b;
    logic zu, cu, nc, c;
    w = 8'($random(seed));
    f = 8'($random(seed));
    b = 3'($random(seed));
    @(posedge aclk);
    opv <= 1;
    op <= o;
    ow <= w;
    of <= f;
    bi <= b;
    dst <= d;
    if (d) f = m;
    zu = 1;
    cu = 0;
    nc = 0;
    c = 0;
    case (o)
      csfbs_pkg::op_add: begin
        r = f + w;
        cu = 1;
        c = r[8];
        nc = f[3:0] + w[3:0] > 15;
      end
      csfbs_pkg::op_sub: begin
        r = f - w;
        cu = 1;
        c = f >= w;
        nc = f[3:0] >= w[3:0];
      end
      csfbs_pkg::op_and: r = f & w;
      csfbs_pkg::op_or: r = f | w;
      csfbs_pkg::op_xor: r = f ^ w;
      csfbs_pkg::op_inc: r = f + 9'h001;
      csfbs_pkg::op_dec: r = f - 9'h001;
      csfbs_pkg::op_register_wipe: r = 0;
      csfbs_pkg::op_working_to_register_move: begin
        r = w;
        zu = 0;
      end
      csfbs_pkg::op_nibble_exchange: begin
        r = {f[3:0], f[7:4]};
        zu = 0;
      end
      csfbs_pkg::op_bit_reset: begin
        r = f & ~(8'h1 << b);
        zu = 0;
      end
      default: begin
        r = f | (8'h1 << b);
        zu = 0;
      end
    endcase
    if (d) m = {r[7:5], m[4:3], (zu || cu) ? m[2:0] : r[2:0]};
    if (zu) m[2] = r[7:0] == 0;
    if (cu) m[1:0] = {nc, c};
    @(posedge aclk);
    opv <= 0;
    #1;
    `CHK(res, r[7:0])
    `CHK(fl, m)
    `CHK(rv, 1'b1)
    `CHK(oh, 4'h1 << m[6:5])
    `CHK(ib, m[7])
  endtask : do_op

  task automatic ev(logic [2:0] e);
    @(posedge aclk);
    {kk, sl, tmo} <= e;
    @(posedge aclk);
    {kk, sl, tmo} <= 3'h0;
    if (e[2]) m[4:3] = 2'h3;
    if (e[1]) m[4:3] = 2'h2;
    if (e[0]) m[4] = 0;
    #1;
    `CHK(fl, m)
  endtask : ev

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  // ----------
  // main sequence
  // ----------
  initial begin
    logic [31:0] d;
    logic [3:0] s;
    repeat (3) @(posedge aclk);
    rstn <= 1;
    m = 8'h18;
    #1;
    `CHK(fl, m)
    @(posedge aclk);
    for (int i = 0; i < 48; i++) do_op(ops[i % 12], i[3]);
    $display("test core ops done");
    for (int i = 1; i < 8; i++) ev(i[2:0]);
    $display("test events done");
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      s = 4'($random(seed));
      s[0] = i[0];
      wr(8'h00, d, s, 2'h0);
      if (s[0]) m = (d[7:0] & 8'he7) | (m & 8'h18);
      rd_chk(8'h00, {24'h0, m}, 2'h0);
      rd_chk(8'h04, {27'h0, m[7], 4'h1 << m[6:5]}, 2'h0);
    end
    wr(8'h04, 32'hffff_ffff, 4'hf, 2'h0);
    wr(8'h08, 32'h0000_0000, 4'hf, 2'h3);
    rd_chk(8'h08, 32'h0, 2'h3);
    rd_chk(8'h00, {24'h0, m}, 2'h0);
    $display("test bus done");
    @(posedge aclk);
    rstn <= 0;
    repeat (3) @(posedge aclk);
    rstn <= 1;
    m = 8'h18;
    #1;
    `CHK(fl, m)
    `CHK(oh, 4'h1)
    `CHK(ib, 1'b0)
    `CHK(bv, 1'b0)
    `CHK(rvl, 1'b0)
    rd_chk(8'h00, {24'h0, m}, 2'h0);
    $display("test reset done");
    final_report();
  end
endmodule : csfbs_top_test

`default_nettype wire
